//--- core/core_seq_pkg.sv
package core_seq_pkg;
  // ==========================================================
  // widths
  localparam int SYL_W = 14;
  localparam int LOC_W = 12;
  localparam int SECT_W = 4;
  localparam int WORD_W = 8;
  localparam int MOD_W = 3;
  localparam int OPD_W = 28;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WORD = 8'h04;
  localparam logic [7:0] OFS_ISECT = 8'h08;
  localparam logic [7:0] OFS_DSECT = 8'h0C;
  localparam logic [7:0] OFS_MODULE = 8'h10;
  localparam logic [7:0] OFS_WDATA = 8'h14;
  localparam logic [7:0] OFS_RDATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  // ==========================================================
  // control fields and access kinds
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_SYL = 3;
  localparam logic [1:0] OP_FETCH = 2'h0;
  localparam logic [1:0] OP_OPD_RD = 2'h1;
  localparam logic [1:0] OP_OPD_ST = 2'h2;
  localparam logic [1:0] OP_INS_ST = 2'h3;
  // ==========================================================
  // interrupt bits
  localparam int EV_DONE = 0;
  localparam int EV_PAR = 1;
  localparam int EV_RESID = 2;
  localparam int EV_W = 3;
  // ==========================================================
  // reset values and special sectors
  localparam logic [SECT_W-1:0] RESID_SECT = 4'hF;
  localparam logic [SECT_W-1:0] SECT_RST = 4'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  localparam logic [MOD_W-1:0] MOD_RST = 3'h0;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  // ==========================================================
  // phase timing
  localparam int CLK_NS = 40;
  localparam int PHASE_NS = 160;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYC - 1);
  // ==========================================================
  // sequencer states
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_RGEN = 7'b0000010,
    S_RSYL = 7'b0000100,
    S_SAMP = 7'b0001000,
    S_SSYL = 7'b0010000,
    S_SGEN = 7'b0100000,
    S_DONE = 7'b1000000
  } seq_state_t;
endpackage

//--- core/sense_sync.sv
`timescale 1ns/1ps
module sense_sync
  import core_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [SYL_W-1:0] din,
  output logic [SYL_W-1:0] dout
);
  // ==========================================================
  // three stage chain per bit, output follows once stages two and three agree
  // each bit keeps its own flops so that no vector is written by several processes
  genvar i;
  generate
    for (i = 0; i < SYL_W; i++) begin : g_bit
      logic ff1_r, ff2_r, ff3_r, out_r;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ff1_r <= 1'b0;
          ff2_r <= 1'b0;
          ff3_r <= 1'b0;
          out_r <= 1'b0;
        end else begin
          ff1_r <= din[i];
          ff2_r <= ff1_r;
          ff3_r <= ff2_r;
          if (ff2_r == ff3_r) begin
            out_r <= ff3_r;
          end
        end
      end
      assign dout[i] = out_r;
    end
  endgenerate
endmodule // sense_sync

//--- core/parity_check.sv
`timescale 1ns/1ps
module parity_check
  import core_seq_pkg::*;
(
  input wire logic [SYL_W-1:0] word,
  output logic odd_ok
);
  // ==========================================================
  // odd count of ones means the word is good
  assign odd_ok = ^word;
endmodule // parity_check

//--- core/core_seq.sv
`timescale 1ns/1ps
module core_seq
  import core_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic [7:0] mod_sel,
  output logic [7:0] y_hi,
  output logic [7:0] y_lo,
  output logic [7:0] x1_hi,
  output logic [7:0] x1_lo,
  output logic [7:0] x2_hi,
  output logic [7:0] x2_lo,
  output logic drive_rd,
  output logic [SYL_W-1:0] inhibit,
  input wire logic [SYL_W-1:0] sense,
  output logic residual
);
  // ==========================================================
  // declarations
  seq_state_t state_r, state_nxt;
  logic [3:0] cnt_r;
  logic phase_end;
  logic [SECT_W-1:0] isect_r, dsect_r;
  logic [WORD_W-1:0] word_r;
  logic [MOD_W-1:0] module_r;
  logic [OPD_W-1:0] wdata_r, rdata_r;
  logic [EV_W-1:0] irq_stat_r, irq_mask_r, ev;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic start;
  logic [1:0] start_op;
  logic [LOC_W-1:0] acc_loc_r;
  logic acc_syl_r, acc_two_r, acc_store_r;
  logic [MOD_W-1:0] acc_mod_r;
  logic [SYL_W-1:0] buf_r [2];
  logic [SYL_W-1:0] sensed;
  logic odd_ok;
  logic grp;
  logic par_err;
  logic [31:0] rd_mux;
  logic resid_sect;
  logic busy;

  // ==========================================================
  // helpers
  // three bits to one of eight driver enables
  function automatic logic [7:0] onehot8(input logic [2:0] v);
    onehot8 = 8'h01 << v;
  endfunction

  // ==========================================================
  // sense path
  sense_sync i_sense_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(sense),
    .dout(sensed)
  );

  parity_check i_parity_check (
    .word(sensed),
    .odd_ok(odd_ok)
  );

  // ==========================================================
  // bus slave: address phase capture, zero wait answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_r <= hwrite;
        wr_addr_r <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_mux;
        end
      end
    end
  end

  // read data selection, unmapped reads zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      OFS_WORD: rd_mux[WORD_W-1:0] = word_r;
      OFS_ISECT: rd_mux[SECT_W-1:0] = isect_r;
      OFS_DSECT: rd_mux[SECT_W-1:0] = dsect_r;
      OFS_MODULE: rd_mux[MOD_W-1:0] = module_r;
      OFS_WDATA: rd_mux[OPD_W-1:0] = wdata_r;
      OFS_RDATA: rd_mux[OPD_W-1:0] = rdata_r;
      OFS_STATUS: rd_mux[9:0] = {resid_sect, busy, state_r, grp};
      OFS_IRQ_STAT: rd_mux[EV_W-1:0] = irq_stat_r;
      OFS_IRQ_MASK: rd_mux[EV_W-1:0] = irq_mask_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // go is taken only while idle
  assign start = wr_pend_r && (wr_addr_r == OFS_CTRL) && hwdata[CTRL_GO] && (state_r == S_IDLE);
  assign start_op = hwdata[CTRL_OP_LSB +: 2];

  // ==========================================================
  // software config, frozen while an access runs except the interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_r <= WORD_RST;
      isect_r <= SECT_RST;
      dsect_r <= SECT_RST;
      wdata_r <= '0;
      irq_mask_r <= MASK_RST;
    end else if (wr_pend_r) begin
      if (wr_addr_r == OFS_IRQ_MASK) begin
        irq_mask_r <= hwdata[EV_W-1:0];
      end
      if (state_r == S_IDLE) begin
        case (wr_addr_r)
          OFS_WORD: word_r <= hwdata[WORD_W-1:0];
          OFS_ISECT: isect_r <= hwdata[SECT_W-1:0];
          OFS_DSECT: dsect_r <= hwdata[SECT_W-1:0];
          OFS_WDATA: wdata_r <= hwdata[OPD_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // single module register, flips to partner on parity error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_r <= MOD_RST;
    end else if (par_err) begin
      module_r <= module_r ^ 3'h1;
    end else if (wr_pend_r && wr_addr_r == OFS_MODULE && state_r == S_IDLE) begin
      module_r <= hwdata[MOD_W-1:0];
    end
  end

  // ==========================================================
  // access latch taken at start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_loc_r <= '0;
      acc_syl_r <= 1'b0;
      acc_two_r <= 1'b0;
      acc_store_r <= 1'b0;
      acc_mod_r <= MOD_RST;
    end else if (start) begin
      // operands use data sector, instructions use instruction sector
      if (start_op == OP_OPD_RD || start_op == OP_OPD_ST) begin
        acc_loc_r <= {dsect_r, word_r};
        acc_two_r <= 1'b1;
        acc_syl_r <= 1'b0;
      end else begin
        acc_loc_r <= {isect_r, word_r};
        acc_two_r <= 1'b0;
        acc_syl_r <= hwdata[CTRL_SYL];
      end
      acc_store_r <= start_op[1];
      acc_mod_r <= module_r;
    end else if (state_r == S_SGEN && phase_end && acc_two_r && !acc_syl_r) begin
      acc_syl_r <= 1'b1;
    end
  end

  assign grp = acc_mod_r[0];
  assign phase_end = (cnt_r == PHASE_LAST);
  assign par_err = (state_r == S_SAMP) && phase_end && !acc_store_r && !odd_ok;
  // latched access targets the residual sector; sequencer away from idle
  assign resid_sect = (acc_loc_r[LOC_W-1:WORD_W] == RESID_SECT);
  assign busy = !state_r[0];

  // ==========================================================
  // sequencer: read then restore or store per syllable
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: if (start) state_nxt = S_RGEN;
      S_RGEN: if (phase_end) state_nxt = S_RSYL;
      S_RSYL: if (phase_end) state_nxt = S_SAMP;
      S_SAMP: if (phase_end) state_nxt = S_SSYL;
      S_SSYL: if (phase_end) state_nxt = S_SGEN;
      S_SGEN: begin
        if (phase_end) begin
          state_nxt = (acc_two_r && !acc_syl_r) ? S_RGEN : S_DONE;
        end
      end
      S_DONE: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r || state_r == S_IDLE) ? 4'h0 : cnt_r + 4'h1;
    end
  end

  // ==========================================================
  // group buffer registers and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      rdata_r <= '0;
    end else if (state_r == S_SAMP && phase_end) begin
      if (acc_store_r) begin
        // new data replaces the cleared word
        buf_r[grp] <= acc_syl_r ? wdata_r[OPD_W-1:SYL_W] : wdata_r[SYL_W-1:0];
      end else begin
        buf_r[grp] <= sensed;
        if (!acc_two_r) begin
          rdata_r <= {14'h0000, sensed};
        end else if (!acc_syl_r) begin
          rdata_r[SYL_W-1:0] <= sensed;
        end else begin
          rdata_r[OPD_W-1:SYL_W] <= sensed;
        end
      end
    end
  end

  // ==========================================================
  // core drivers, registered from the current phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      y_hi <= 8'h00;
      y_lo <= 8'h00;
      x1_hi <= 8'h00;
      x1_lo <= 8'h00;
      x2_hi <= 8'h00;
      x2_lo <= 8'h00;
      drive_rd <= 1'b0;
      inhibit <= '0;
      mod_sel <= 8'h00;
    end else begin
      y_hi <= 8'h00;
      y_lo <= 8'h00;
      x1_hi <= 8'h00;
      x1_lo <= 8'h00;
      x2_hi <= 8'h00;
      x2_lo <= 8'h00;
      inhibit <= '0;
      mod_sel <= state_r[0] ? 8'h00 : onehot8(acc_mod_r);
      // y spans both syllables, on before x in the read and with x in the store; off together with x after the read, off after x in the store
      if (state_r == S_RGEN || state_r == S_RSYL || state_r == S_SSYL || state_r == S_SGEN) begin
        y_hi <= onehot8(acc_loc_r[11:9]);
        y_lo <= onehot8(acc_loc_r[8:6]);
      end
      if (state_r == S_RSYL || state_r == S_SSYL) begin
        if (!acc_syl_r) begin
          x1_hi <= onehot8(acc_loc_r[5:3]);
          x1_lo <= onehot8(acc_loc_r[2:0]);
        end else begin
          x2_hi <= onehot8(acc_loc_r[5:3]);
          x2_lo <= onehot8(acc_loc_r[2:0]);
        end
      end
      // read current flows high to low, store low to high
      if (state_r == S_RGEN || state_r == S_RSYL) begin
        drive_rd <= 1'b1;
      end else if (state_r == S_SSYL || state_r == S_SGEN) begin
        drive_rd <= 1'b0;
      end
      if (state_r == S_SSYL || state_r == S_SGEN) begin
        inhibit <= ~buf_r[grp];
      end
    end
  end

  // ==========================================================
  // events, sticky status, mask and interrupt
  always_comb begin
    ev = '0;
    ev[EV_DONE] = (state_r == S_DONE);
    ev[EV_PAR] = par_err;
    ev[EV_RESID] = (state_r == S_RGEN) && (cnt_r == 4'h0) && resid_sect;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
      residual <= 1'b0;
    end else begin
      // set wins over a write-one clear
      if (wr_pend_r && wr_addr_r == OFS_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~hwdata[EV_W-1:0]) | ev;
      end else begin
        irq_stat_r <= irq_stat_r | ev;
      end
      irq <= |(irq_stat_r & irq_mask_r);
      residual <= busy && resid_sect;
    end
  end

  // upper address bits and transfer size are not decoded
  logic unused_ok;
  assign unused_ok = ^{haddr[31:8], hsize};
endmodule // core_seq

//--- dv/core_seq_properties.sv
`timescale 1ns/1ps
// ==========================================================
// drive sequencing checker, sees only the top ports
module core_seq_checker
  import core_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] mod_sel,
  input wire logic [7:0] y_hi,
  input wire logic [7:0] y_lo,
  input wire logic [7:0] x1_hi,
  input wire logic [7:0] x1_lo,
  input wire logic [7:0] x2_hi,
  input wire logic [7:0] x2_lo,
  input wire logic drive_rd,
  input wire logic [SYL_W-1:0] inhibit
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // any x drive, any y drive
  wire logic xa = (|x1_lo) || (|x2_lo);
  wire logic ya = |y_lo;
  // syllable read phase then all drivers off
  sequence s_rd_tail;
    (xa && ya && drive_rd) [*4] ##1 (!xa && !ya);
  endsequence
  // syllable store phase then general store phase
  sequence s_st_tail;
    (xa && ya && !drive_rd) [*4] ##1 (!xa && ya && !drive_rd) [*4];
  endsequence
  property p_read_seq;
    (drive_rd && $rose(xa)) |-> s_rd_tail;
  endproperty
  property p_store_seq;
    (!drive_rd && $rose(xa)) |-> s_st_tail;
  endproperty
  property p_y_before_x;
    (drive_rd && $rose(xa)) |-> $past(ya, 1) && $past(ya, 4) && !$past(xa, 1);
  endproperty
  property p_onehot;
    $onehot0(y_hi) && $onehot0(y_lo) && $onehot0(x1_hi) && $onehot0(x1_lo) && $onehot0(x2_hi) && $onehot0(x2_lo)
      && ((|y_hi) == (|y_lo)) && ((|x1_hi) == (|x1_lo)) && ((|x2_hi) == (|x2_lo));
  endproperty
  property p_one_syl;
    !((|x1_lo) && (|x2_lo));
  endproperty
  property p_inhibit_store;
    (|inhibit) |-> (!drive_rd && ya);
  endproperty
  property p_y_hold;
    (ya && $past(ya)) |-> ($stable(y_hi) && $stable(y_lo));
  endproperty
  property p_sel_active;
    xa |-> ($onehot(mod_sel));
  endproperty
  a_read_seq: assert property (p_read_seq) else $error("read phase order wrong");
  a_store_seq: assert property (p_store_seq) else $error("store phase order wrong");
  a_y_before_x: assert property (p_y_before_x) else $error("x drive before y drive");
  a_onehot: assert property (p_onehot) else $error("driver pairs not one-hot");
  a_one_syl: assert property (p_one_syl) else $error("both syllables driven");
  a_inhibit_store: assert property (p_inhibit_store) else $error("inhibit outside store");
  a_y_hold: assert property (p_y_hold) else $error("address moved in access");
  a_sel_active: assert property (p_sel_active) else $error("no single module selected");
endmodule // core_seq_checker

bind core_seq core_seq_checker i_core_seq_checker (.hclk(hclk), .hresetn(hresetn), .mod_sel(mod_sel), .y_hi(y_hi),
  .y_lo(y_lo), .x1_hi(x1_hi), .x1_lo(x1_lo), .x2_hi(x2_hi), .x2_lo(x2_lo), .drive_rd(drive_rd), .inhibit(inhibit));

//--- dv/core_array_model.sv
`timescale 1ns/1ps
// ==========================================================
// two-syllable core array with shared sense amplifiers
module core_array_model
  import core_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic [7:0] y_hi,
  input wire logic [7:0] y_lo,
  input wire logic [7:0] x1_hi,
  input wire logic [7:0] x1_lo,
  input wire logic [7:0] x2_hi,
  input wire logic [7:0] x2_lo,
  input wire logic drive_rd,
  input wire logic [SYL_W-1:0] inhibit,
  output logic [SYL_W-1:0] sense
);
  logic [SYL_W-1:0] mem [2][4096];
  logic xon_r;
  logic [11:0] loc;
  logic syl;
  // one-hot driver group to index
  function automatic logic [2:0] idx(input logic [7:0] v);
    idx = 3'h0;
    for (int i = 0; i < 8; i++) if (v[i]) idx = 3'(i);
  endfunction
  // paired high and low drivers pick one of 4096 places
  assign syl = |x2_lo;
  assign loc = {idx(y_hi), idx(y_lo), syl ? idx(x2_hi) : idx(x1_hi), syl ? idx(x2_lo) : idx(x1_lo)};
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[0][i] = 14'h0001;
      mem[1][i] = 14'h0001;
    end
    sense = 14'h0000;
    xon_r = 1'b0;
  end
  // destructive read on shared sense lines, store writes where no inhibit
  always @(posedge hclk) begin
    xon_r <= (|x1_lo) || (|x2_lo);
    if (((|x1_lo) || (|x2_lo)) && (|y_lo)) begin
      if (drive_rd && !xon_r) begin
        sense <= mem[syl][loc];
        mem[syl][loc] <= 14'h0000;
      end else if (!drive_rd) begin
        mem[syl][loc] <= ~inhibit;
        if (!xon_r) sense <= ~sense; // released amplifier output
      end
    end
  end
endmodule // core_array_model

//--- dv/core_seq_tb.sv
`timescale 1ns/1ps
module core_seq_tb
  import core_seq_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, drive_rd, residual;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] mod_sel, y_hi, y_lo, x1_hi, x1_lo, x2_hi, x2_lo;
  logic [SYL_W-1:0] inhibit, sense;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  core_seq i_core_seq (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .mod_sel(mod_sel), .y_hi(y_hi), .y_lo(y_lo), .x1_hi(x1_hi), .x1_lo(x1_lo), .x2_hi(x2_hi),
    .x2_lo(x2_lo), .drive_rd(drive_rd), .inhibit(inhibit), .sense(sense), .residual(residual));
  core_array_model i_core_array_model (.hclk(hclk), .y_hi(y_hi), .y_lo(y_lo), .x1_hi(x1_hi), .x1_lo(x1_lo),
    .x2_hi(x2_hi), .x2_lo(x2_lo), .drive_rd(drive_rd), .inhibit(inhibit), .sense(sense));
  // ==========================================================
  // clock, reset, timeout
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // ==========================================================
  // bus master: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] u;
    bus(1'b1, a, v, u);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h00000000, v);
  endtask
  // start an access and poll busy until it clears
  task automatic run(input logic [1:0] op, input logic syl);
    wr(OFS_CTRL, {28'h0000000, syl, op, 1'b1});
    do begin rd(OFS_STATUS, d); end while (d[8] !== 1'b0);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] ofs [7];
    ofs = '{OFS_WORD, OFS_ISECT, OFS_DSECT, OFS_MODULE, OFS_STATUS, OFS_IRQ_MASK, 8'h40};
    foreach (ofs[i]) begin
      rd(ofs[i], d);
      chk(d, (ofs[i] == OFS_STATUS) ? {22'h000000, 1'b0, 1'b0, S_IDLE, 1'b0} : 32'h00000000, "reset value");
    end
    chk({30'h0, hresp, hreadyout}, 32'h00000001, "bus response");
    $display("test reset done");
  endtask
  task automatic t_operand();
    wr(OFS_DSECT, 32'h00000005);
    wr(OFS_ISECT, 32'h00000002);
    wr(OFS_WORD, 32'h0000003A);
    wr(OFS_WDATA, {4'h0, 14'h0007, 14'h1C00});
    run(OP_OPD_ST, 1'b0);
    chk(32'(i_core_array_model.mem[0][12'h53A]), 32'h00001C00, "syllable 1 stored");
    chk(32'(i_core_array_model.mem[1][12'h53A]), 32'h00000007, "syllable 2 stored");
    wr(OFS_WDATA, 32'h00000000);
    run(OP_OPD_RD, 1'b0);
    rd(OFS_RDATA, d);
    chk(d, {4'h0, 14'h0007, 14'h1C00}, "operand read");
    chk(32'(i_core_array_model.mem[0][12'h53A]), 32'h00001C00, "restored after read");
    rd(OFS_IRQ_STAT, d);
    chk(d & 32'h1, 32'h00000001, "done event");
    wr(OFS_IRQ_STAT, 32'h00000007);
    rd(OFS_IRQ_STAT, d);
    chk(d, 32'h00000000, "events cleared");
    $display("test operand done");
  endtask
  task automatic t_fetch();
    wr(OFS_WORD, 32'h00000010);
    wr(OFS_WDATA, {4'h0, 14'h0015, 14'h0000});
    run(OP_INS_ST, 1'b1);
    chk(32'(i_core_array_model.mem[1][12'h210]), 32'h00000015, "instruction stored in sector");
    chk(32'(i_core_array_model.mem[0][12'h210]), 32'h00000001, "other syllable kept");
    run(OP_FETCH, 1'b1);
    rd(OFS_RDATA, d);
    chk(d, 32'h00000015, "fetch one syllable");
    $display("test fetch done");
  endtask
  task automatic t_resid();
    wr(OFS_DSECT, 32'h0000000F);
    wr(OFS_IRQ_MASK, 32'h00000004);
    wr(OFS_CTRL, {28'h0000000, 1'b0, OP_OPD_RD, 1'b1});
    rd(OFS_STATUS, d);
    chk({29'h00000000, d[9], d[8], residual}, 32'h00000007, "residual access active");
    do begin rd(OFS_STATUS, d); end while (d[8] !== 1'b0);
    chk({31'h00000000, residual}, 32'h00000000, "residual released");
    rd(OFS_IRQ_STAT, d);
    chk(d & 32'h4, 32'h00000004, "residual event");
    chk({31'h0, irq}, 32'h00000001, "irq raised");
    wr(OFS_IRQ_MASK, 32'h00000000);
    rd(OFS_IRQ_STAT, d);
    chk({31'h0, irq}, 32'h00000000, "irq masked");
    wr(OFS_IRQ_MASK, 32'h00000004);
    wr(OFS_IRQ_STAT, 32'h00000007);
    rd(OFS_IRQ_STAT, d);
    chk({d[2], irq}, 32'h00000000, "irq cleared");
    $display("test residual done");
  endtask
  task automatic t_parity();
    i_core_array_model.mem[0][12'h220] = 14'h0003;
    wr(OFS_WORD, 32'h00000020);
    run(OP_FETCH, 1'b0);
    rd(OFS_IRQ_STAT, d);
    chk(d & 32'h2, 32'h00000002, "parity error flagged");
    rd(OFS_MODULE, d);
    chk(d, 32'h00000001, "partner module selected");
    $display("test parity done");
  endtask
  task automatic t_busy();
    wr(OFS_CTRL, {28'h0000000, 1'b0, OP_OPD_RD, 1'b1});
    wr(OFS_WORD, 32'h00000077);
    run(OP_FETCH, 1'b0);
    rd(OFS_WORD, d);
    chk(d, 32'h00000020, "write refused while busy");
    $display("test busy done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_operand();
    t_fetch();
    t_resid();
    t_parity();
    t_busy();
    summarize();
  end
endmodule // core_seq_tb
